// ### design/adcc_cfg.svh
`ifndef ADCC_CFG_SVH
`define ADCC_CFG_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define ADCC_OFS_CTRL0   4'h0
`define ADCC_OFS_CTRL1   4'h1
`define ADCC_OFS_CTRL2   4'h2
`define ADCC_OFS_RESH    4'h3
`define ADCC_OFS_RESL    4'h4
`define ADCC_OFS_FLAG    4'h5
`define ADCC_OFS_IRQEN   4'h6
`define ADCC_RESET_BYTE  8'h00
// ------------------------------------------------------------
// timing and codes
// ------------------------------------------------------------
`define ADCC_CONV_PERIODS 4'hf
`define ADCC_NEG_SINGLE   4'hf
`define ADCC_RC_SEL_LOW   2'h3
`define ADCC_TRIG_CCP_A   4'h1
`define ADCC_TRIG_CCP_B   4'h2
`define ADCC_TRIG_SMA_LO  4'h4
`define ADCC_TRIG_SMB_HI  4'h9
`define ADCC_SYNC_ONE     3'h7
`endif

// ### design/adcc_pkg.sv
package adcc_pkg;
   typedef enum logic [1:0] {adcc_idle, adcc_delay, adcc_conv} adcc_state_t;
   typedef struct packed {
      logic [4:0] pos_channel_sel;
      logic       go;
      logic       converter_enable;
      logic       result_format_sel;
      logic [2:0] conv_clock_sel;
      logic       neg_reference_sel;
      logic [1:0] pos_reference_sel;
      logic [3:0] trigger_source_sel;
      logic [3:0] neg_channel_sel;
      logic [7:0] result_high;
      logic [7:0] result_low;
      logic       conv_done_flag;
      logic       conv_done_irq_enable;
      logic [7:0] rd_data;
      adcc_state_t state;
      logic [6:0] div_cnt;
      logic       tick;
      logic [3:0] period_cnt;
      logic [11:0] mag;
      logic       sign;
      logic [2:0] rc_sync;
      logic       rc_prev;
      logic [2:0] bit_sync;
      logic [7:0] trig_prev;
      logic       timer_clear;
      logic       wake;
      logic       core_on;
      logic       sample;
   } adcc_state_reg_t;
endpackage : adcc_pkg

// ### design/adcc_top.sv
`timescale 1ns/1ps
`include "adcc_cfg.svh"
module adcc_top
   import adcc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       rst_b,
   input  wire logic [3:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       sleep_active,
   input  wire logic       rc_clk,
   input  wire logic       core_bit,
   input  wire logic [7:0] trig_events,
   output logic      [4:0] pos_channel_sel,
   output logic      [3:0] neg_channel_sel,
   output logic      [1:0] pos_reference_sel,
   output logic            neg_reference_sel,
   output logic            core_on,
   output logic            core_sample,
   output logic            conv_done_flag,
   output logic            wake_request,
   output logic            timer_clear
);
   adcc_state_reg_t r;
   adcc_state_reg_t next_r;
   logic            rc_sel;
   logic            trig_now;
   logic            trig_was;
   logic            rc_rise;
   logic            bit_val;
   logic [6:0]      div_top;
   logic [11:0]     twos;
   logic            finish;
   logic            abort;

   // ------------------------------------------------------------
   // selection helpers
   // ------------------------------------------------------------
   // rc oscillator chosen for codes x11
   assign rc_sel = (r.conv_clock_sel[1:0] == `ADCC_RC_SEL_LOW);
   // trigger source mux, unused codes disable
   always_comb begin
      trig_now = 1'b0;
      trig_was = 1'b0;
      if (r.trigger_source_sel == `ADCC_TRIG_CCP_A) begin
         trig_now = trig_events[0];
         trig_was = r.trig_prev[0];
      end else if (r.trigger_source_sel == `ADCC_TRIG_CCP_B) begin
         trig_now = trig_events[1];
         trig_was = r.trig_prev[1];
      end else if (r.trigger_source_sel >= `ADCC_TRIG_SMA_LO &&
                   r.trigger_source_sel <= `ADCC_TRIG_SMB_HI) begin
         trig_now = trig_events[r.trigger_source_sel[2:0] - 3'h2];
         trig_was = r.trig_prev[r.trigger_source_sel[2:0] - 3'h2];
      end
   end
   // divider terminal count from clock select
   always_comb begin
      case (r.conv_clock_sel)
         3'h0:    div_top = 7'h01;
         3'h4:    div_top = 7'h03;
         3'h1:    div_top = 7'h07;
         3'h5:    div_top = 7'h0f;
         3'h2:    div_top = 7'h1f;
         3'h6:    div_top = 7'h3f;
         default: div_top = 7'h01;
      endcase
   end
   // rc edge after three-stage synchroniser, second and third agree
   assign rc_rise = r.rc_sync[2] & r.rc_sync[1] & ~r.rc_prev;
   assign bit_val = r.bit_sync[2];
   // two's complement view of the sign-magnitude result
   assign twos = r.sign ? (12'h000 - r.mag) : r.mag;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      next_r             = r;
      next_r.rc_sync     = {r.rc_sync[1:0], rc_clk};
      next_r.bit_sync    = {r.bit_sync[1:0], core_bit};
      if (r.rc_sync[2] == r.rc_sync[1]) begin
         next_r.rc_prev = r.rc_sync[2];
      end
      next_r.trig_prev   = trig_events;
      next_r.timer_clear = 1'b0;
      next_r.wake        = 1'b0;
      next_r.tick        = 1'b0;
      next_r.sample      = 1'b0;
      next_r.rd_data     = `ADCC_RESET_BYTE;
      finish             = 1'b0;
      abort              = 1'b0;
      // bit period tick from system divider or rc edges
      if (rc_sel) begin
         next_r.tick = rc_rise;
      end else if (r.div_cnt >= div_top) begin
         next_r.div_cnt = 7'h00;
         next_r.tick    = 1'b1;
      end else begin
         next_r.div_cnt = r.div_cnt + 7'h01;
      end
      // register reads, data valid next cycle
      if (reg_rd) begin
         if (reg_addr == `ADCC_OFS_CTRL0) begin
            next_r.rd_data = {1'b0, r.pos_channel_sel, r.go, r.converter_enable};
         end else if (reg_addr == `ADCC_OFS_CTRL1) begin
            next_r.rd_data = {r.result_format_sel, r.conv_clock_sel, 1'b0,
                              r.neg_reference_sel, r.pos_reference_sel};
         end else if (reg_addr == `ADCC_OFS_CTRL2) begin
            next_r.rd_data = {r.trigger_source_sel, r.neg_channel_sel};
         end else if (reg_addr == `ADCC_OFS_RESH) begin
            next_r.rd_data = r.result_high;
         end else if (reg_addr == `ADCC_OFS_RESL) begin
            next_r.rd_data = r.result_low;
         end else if (reg_addr == `ADCC_OFS_FLAG) begin
            next_r.rd_data = {7'h00, r.conv_done_flag};
         end else if (reg_addr == `ADCC_OFS_IRQEN) begin
            next_r.rd_data = {7'h00, r.conv_done_irq_enable};
         end
      end
      // register writes
      if (reg_wr) begin
         if (reg_addr == `ADCC_OFS_CTRL0) begin
            next_r.pos_channel_sel  = reg_wdata[6:2];
            next_r.go               = reg_wdata[1];
            next_r.converter_enable = reg_wdata[0];
         end else if (reg_addr == `ADCC_OFS_CTRL1) begin
            next_r.result_format_sel = reg_wdata[7];
            next_r.conv_clock_sel    = reg_wdata[6:4];
            next_r.neg_reference_sel = reg_wdata[2];
            next_r.pos_reference_sel = reg_wdata[1:0];
         end else if (reg_addr == `ADCC_OFS_CTRL2) begin
            next_r.trigger_source_sel = reg_wdata[7:4];
            next_r.neg_channel_sel    = reg_wdata[3:0];
         end else if (reg_addr == `ADCC_OFS_RESH) begin
            next_r.result_high = reg_wdata;
         end else if (reg_addr == `ADCC_OFS_RESL) begin
            next_r.result_low = reg_wdata;
         end else if (reg_addr == `ADCC_OFS_FLAG) begin
            next_r.conv_done_flag = reg_wdata[0];
         end else if (reg_addr == `ADCC_OFS_IRQEN) begin
            next_r.conv_done_irq_enable = reg_wdata[0];
         end
      end
      // hardware trigger sets start when idle only
      if (trig_now && !trig_was && r.state == adcc_idle && r.converter_enable) begin
         next_r.go          = 1'b1;
         next_r.timer_clear = 1'b1;
      end
      // conversion sequencer
      case (r.state)
         adcc_idle: begin
            // an idle core stays off through sleep, even after a finish in sleep
            next_r.core_on = r.converter_enable & ~sleep_active;
            if (next_r.go && !r.go && r.converter_enable) begin
               next_r.result_high = 8'h00;
               next_r.result_low  = 8'h00;
               next_r.mag         = 12'h000;
               next_r.sign        = 1'b0;
               next_r.period_cnt  = 4'h0;
               next_r.core_on     = 1'b1;
               next_r.state       = rc_sel ? adcc_delay : adcc_conv;
            end
         end
         adcc_delay: begin
            next_r.state = adcc_conv;
         end
         adcc_conv: begin
            // trigger edges are ignored while converting
            if (!r.go || !r.converter_enable || (sleep_active && !rc_sel)) begin
               abort = 1'b1;
            end else if (r.tick) begin
               next_r.sample     = 1'b1;
               next_r.period_cnt = r.period_cnt + 4'h1;
               // first decided bit is the sign, then magnitude msb first, entering at the bottom
               if (r.period_cnt == 4'h0) begin
                  next_r.sign = bit_val;
               end else if (r.period_cnt <= 4'hc) begin
                  next_r.mag = {r.mag[10:0], bit_val};
               end
               if (r.period_cnt == `ADCC_CONV_PERIODS - 4'h1) begin
                  finish = 1'b1;
               end
            end
         end
         default: next_r.state = adcc_idle;
      endcase
      if (r.state == adcc_conv && (abort || finish)) begin
         next_r.state = adcc_idle;
      end
      if (abort) begin
         next_r.go = 1'b0;
         if (sleep_active) begin
            next_r.core_on = 1'b0;
         end
      end
      if (finish) begin
         next_r.go             = 1'b0;
         next_r.conv_done_flag = 1'b1;
         if (sleep_active && r.conv_done_irq_enable) begin
            next_r.wake = 1'b1;
         end
         if (sleep_active && !r.conv_done_irq_enable) begin
            next_r.core_on = 1'b0;
         end
      end
      // result registers follow the shift during conversion
      if (r.state == adcc_conv) begin
         if (r.result_format_sel) begin
            next_r.result_high = {{4{r.sign}}, twos[11:8]};
            next_r.result_low  = twos[7:0];
         end else begin
            next_r.result_high = r.mag[11:4];
            next_r.result_low  = {r.mag[3:0], 3'h0, r.sign};
         end
      end
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   // outputs straight from flip-flops
   assign reg_rdata         = r.rd_data;
   assign pos_channel_sel   = r.pos_channel_sel;
   assign neg_channel_sel   = r.neg_channel_sel;
   assign pos_reference_sel = r.pos_reference_sel;
   assign neg_reference_sel = r.neg_reference_sel;
   assign core_on           = r.core_on;
   assign core_sample       = r.sample;
   assign conv_done_flag    = r.conv_done_flag;
   assign wake_request      = r.wake;
   assign timer_clear       = r.timer_clear;
endmodule : adcc_top

// ### dv/adc_conversion_control_test.sv
`timescale 1ns/1ps
module adc_conversion_control_test;
   logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, sleep_active = 0, rc_clk = 0, ld = 0;
   logic [3:0] reg_addr = 0;
   logic [7:0] reg_wdata = 0, trig_events = 0, rdv, reg_rdata;
   logic [12:0] code = 0;
   logic [4:0] pch;
   logic [3:0] nch;
   logic [1:0] pref;
   logic nref, core_bit, core_on, core_sample, flag, wake, tclr, seen;
   int err_total = 0, n_compared = 0, cyc = 0, dur;
   adcc_top dut (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .sleep_active, .rc_clk, .core_bit, .trig_events, .pos_channel_sel(pch),
      .neg_channel_sel(nch), .pos_reference_sel(pref), .neg_reference_sel(nref), .core_on,
      .core_sample, .conv_done_flag(flag), .wake_request(wake), .timer_clear(tclr));
   adcc_core_model u_core (.sys_clk, .rst_b, .load(ld), .code, .core_sample, .core_bit);
   initial forever #50 sys_clk = ~sys_clk;
   initial begin #37; forever #500 rc_clk = ~rc_clk; end
   always @(posedge sys_clk) begin cyc++; if (cyc == 30000) begin err_total++; test_done(); end end
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : test_done
   task automatic check(input string nm, input logic [15:0] sn, input logic [15:0] ex);
      n_compared++;
      if (sn !== ex) begin err_total++; $display("ERROR %s expected %h seen %h", nm, ex, sn); end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= d; end
      @(posedge sys_clk) reg_wr <= 0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk) begin reg_rd <= 1; reg_addr <= a; end
      @(posedge sys_clk) reg_rd <= 0;
      #1 d = reg_rdata;
   endtask : rd
   // all registers at reset value, unmapped index reads zero
   task automatic reset_vals();
      for (int a = 0; a < 8; a++) begin rd(a == 7 ? 4'hf : a[3:0], rdv); check("rst", rdv, 0); end
   endtask : reset_vals
   task automatic start(input logic [12:0] c);
      @(posedge sys_clk) begin ld <= 1; code <= c; end
      @(posedge sys_clk) ld <= 0;
      wr(4'h5, 8'h00);
      wr(4'h0, 8'h01);
      wr(4'h0, 8'h03);
   endtask : start
   task automatic conv(input logic f, input logic [2:0] cs, input int dv, input logic slp,
                       input logic s, input logic [11:0] m);
      logic [11:0] v;
      int          ns;
      int          t0;
      wr(4'h1, {f, cs, 4'h0});
      wr(4'h6, {7'h00, slp});
      start({m, s});
      sleep_active <= slp;
      seen = 0;
      ns   = 0;
      t0   = 0;
      // values read at an edge are those registered at the edge before
      for (dur = 0; dur < 2000 && flag !== 1'b1; dur++) begin
         @(posedge sys_clk);
         seen |= (wake === 1);
         if (core_sample === 1'b1) begin
            if (ns == 0) t0 = dur;
            ns++;
         end
      end
      sleep_active <= 0;
      check("lead", 16'(t0 < dv + 5), 1);
      check("ticks", 16'(ns), 16'd15);
      check("span", 16'(dur - t0 - 1), 16'(14 * dv));
      check("wake", seen, slp);
      rd(4'h0, rdv); check("go", rdv, 8'h01);
      rd(4'h5, rdv); check("flag", rdv, 8'h01);
      v = s ? -m : m;
      rd(4'h3, rdv); check("high", rdv, f ? {{4{s}}, v[11:8]} : m[11:4]);
      rd(4'h4, rdv); check("low", rdv, f ? v[7:0] : {m[3:0], 3'b000, s});
   endtask : conv
   task automatic pulse_trig(input logic [7:0] ev);
      trig_events <= ev;
      seen = 0;
      repeat (10) @(posedge sys_clk) seen |= (tclr === 1);
      trig_events <= 0;
   endtask : pulse_trig
   task automatic trig_codes();
      logic [3:0] tc [8] = '{4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
      wr(4'h1, 8'h60);
      for (int i = 0; i < 8; i++) begin
         wr(4'h2, {tc[i], 4'hf});
         wr(4'h0, 8'h01);
         pulse_trig(8'h01 << i); check("tclr", seen, 1);
         rd(4'h0, rdv); check("trig go", rdv, 8'h03);
         pulse_trig(8'hff); check("busy tclr", seen, 0);
         wr(4'h0, 8'h01);
      end
      wr(4'h2, 8'h3f);
      pulse_trig(8'hff); check("off tclr", seen, 0);
      rd(4'h0, rdv); check("off go", rdv, 8'h01);
   endtask : trig_codes
   task automatic config_fields();
      wr(4'h0, 8'h7c); #1 check("pch", pch, 5'h1f);
      rd(4'h0, rdv); check("ctrl0", rdv, 8'h7c);
      wr(4'h1, 8'h0f); #1 check("refs", {nref, pref}, 3'h7);
      rd(4'h1, rdv); check("ctrl1", rdv, 8'h07);
      wr(4'h2, 8'h0f); #1 check("nch", nch, 4'hf);
      wr(4'hf, 8'hff); rd(4'h2, rdv); check("ctrl2", rdv, 8'h0f);
   endtask : config_fields
   task automatic abort_sleep();
      conv(0, 3'b110, 64, 0, 0, 12'h933);
      start(13'h1fff);
      rd(4'h3, rdv); check("cleared", rdv, 8'h00);
      check("core on", core_on, 1);
      repeat (200) @(posedge sys_clk);
      wr(4'h0, 8'h01);
      repeat (1200) @(posedge sys_clk);
      rd(4'h5, rdv); check("abort flag", rdv, 8'h00);
      start(13'h1fff);
      sleep_active <= 1;
      repeat (1200) @(posedge sys_clk);
      check("core off", core_on, 0);
      sleep_active <= 0;
      rd(4'h5, rdv); check("sleep flag", rdv, 8'h00);
      rd(4'h0, rdv); check("sleep en", rdv & 8'h01, 8'h01);
   endtask : abort_sleep
   initial begin
      repeat (2) @(posedge sys_clk);
      rst_b <= 1;
      reset_vals();
      config_fields();
      conv(1, 3'b001, 8, 0, 1, 12'h001);
      conv(1, 3'b101, 16, 0, 0, 12'h933);
      conv(0, 3'b011, 10, 1, 1, 12'hfff);
      trig_codes();
      abort_sleep();
      start(13'h0123);
      repeat (100) @(posedge sys_clk);
      rst_b <= 0;
      repeat (2) @(posedge sys_clk);
      rst_b <= 1;
      reset_vals();
      test_done();
   end
endmodule : adc_conversion_control_test

// ### dv/adcc_core_model.sv
`timescale 1ns/1ps
// analog core stand-in: one comparator decision per sample pulse
module adcc_core_model (
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        load,
   input  wire logic [12:0] code,
   input  wire logic        core_sample,
   output logic             core_bit
);
   logic [3:0] idx;
   // sign first, then magnitude msb first
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) idx <= 4'h0;
      else if (load) idx <= 4'h0;
      else if (core_sample && idx != 4'hf) idx <= idx + 4'h1;
   end
   assign core_bit = (idx == 4'h0) ? code[0] : (idx < 4'hd) ? code[4'hd - idx] : idx[0];
endmodule : adcc_core_model

// ### dv/adcc_top_checker.sv
`timescale 1ns/1ps
module adcc_top_checker (
   input wire logic       sys_clk,
   input wire logic       rst_b,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic       sleep_active,
   input wire logic [4:0] pos_channel_sel,
   input wire logic [3:0] neg_channel_sel,
   input wire logic [1:0] pos_reference_sel,
   input wire logic       neg_reference_sel,
   input wire logic       core_on,
   input wire logic       core_sample,
   input wire logic       conv_done_flag,
   input wire logic       wake_request,
   input wire logic       timer_clear
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ----------------------------------------
   // register port
   // ----------------------------------------
   property p_rdata_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
   property p_unmapped; reg_rd && reg_addr > 4'h6 |=> reg_rdata == 8'h00; endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_pos_ch; reg_wr && reg_addr == 4'h0 |=> pos_channel_sel == $past(reg_wdata[6:2]);
   endproperty
   a_pos_ch: assert property (p_pos_ch) else $error("positive channel not taken");
   property p_neg_ch; reg_wr && reg_addr == 4'h2 |=> neg_channel_sel == $past(reg_wdata[3:0]);
   endproperty
   a_neg_ch: assert property (p_neg_ch) else $error("negative channel not taken");
   property p_refs;
      reg_wr && reg_addr == 4'h1 |=> {neg_reference_sel, pos_reference_sel} == $past(reg_wdata[2:0]);
   endproperty
   a_refs: assert property (p_refs) else $error("reference select not taken");
   // ----------------------------------------
   // conversion events
   // ----------------------------------------
   property p_flag_hold; conv_done_flag && !(reg_wr && reg_addr == 4'h5) |=> conv_done_flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("done flag dropped by itself");
   property p_timer; timer_clear |=> !timer_clear; endproperty
   a_timer: assert property (p_timer) else $error("timer clear not a pulse");
   property p_wake; wake_request |-> conv_done_flag ##1 !wake_request; endproperty
   a_wake: assert property (p_wake) else $error("wake without done flag");
   property p_sample; core_sample |-> $past(core_on) ##1 !core_sample; endproperty
   a_sample: assert property (p_sample) else $error("decision with core off");
   c_done: cover property ($rose(conv_done_flag));
   c_trig: cover property (timer_clear);
   c_wake: cover property (wake_request);
endmodule : adcc_top_checker
bind adcc_top adcc_top_checker u_chk (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
   .reg_rd, .reg_rdata, .sleep_active, .pos_channel_sel, .neg_channel_sel, .pos_reference_sel,
   .neg_reference_sel, .core_on, .core_sample, .conv_done_flag, .wake_request, .timer_clear);
